// [analog_front_model.sv]
// far-side model: analog input with comparator, timer overflows and convert-start pin
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
	input  wire logic       ref_clk,
	input  wire logic [9:0] sar_dac_code,
	input  wire logic [9:0] input_level,
	output logic            comparator_high,
	output logic            timer3_overflow,
	output logic            timer2_overflow,
	output logic            external_convert_start
);
	// ************************************************************
	// comparator and start sources
	// ************************************************************
	assign comparator_high = (input_level >= sar_dac_code);

	initial begin
		timer3_overflow = 1'b0;
		timer2_overflow = 1'b0;
		external_convert_start = 1'b0;
	end

	// one start event: 1 timer 3, 2 pin rise, 3 timer 2
	task automatic fire(input int src);
		@(posedge ref_clk);
		case (src)
			1: timer3_overflow <= 1'b1;
			2: external_convert_start <= 1'b1;
			default: timer2_overflow <= 1'b1;
		endcase
		@(posedge ref_clk);
		timer3_overflow <= 1'b0;
		timer2_overflow <= 1'b0;
		@(posedge ref_clk);
		external_convert_start <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [sar_adc_control.sv]
// converter control: bus slave, start logic, tracking and successive approximation
// Overview of operation
// - converter, hold and amplifier run only while the enable bit is one
// - nine channels: eight external inputs plus the internal temperature sensor
// - each external input pair set differential or single-ended, changeable between conversions
// - after reset every input pair is single-ended
// - gains one half to sixteen apply to any selected channel
// - reset returns the gain field to unity
// - sar clock is the system clock divided by the divider field plus one
// - conversion starts from software busy write, timer 3, pin edge or timer 2
// - busy is one during a conversion and zero when it completes
// - busy falling at completion sets the done flag at control bit five; clearing enable does not
// - result lands in high and low bytes, left or right justified
// - default track mode tracks continuously whenever no conversion runs
// - low-power mode tracks exactly three sar clocks after each start except a pin start
// - low-power with pin start tracks while pin low, converts on rising edge
// - tracking shuts down while the chip sleeps
// - divider field equals system clock over sar clock, minus one
// - start modes: 00 software, 01 timer 3, 10 pin, 11 timer 2
// - gain codes 000 one, 001 two, 010 four, 011 eight, 10x sixteen, 11x half
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control
	import sar_adc_pkg::*;
#(
	parameter int N_BITS = RESULT_BITS
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              timer3_overflow,
	input  wire logic              timer2_overflow,
	input  wire logic              external_convert_start,
	input  wire logic              chip_sleep,
	input  wire logic              comparator_high,
	output logic                   analog_power_on,
	output logic                   track_enable,
	output logic [N_BITS-1:0]      sar_dac_code,
	output logic [3:0]             channel_select_field,
	output logic [3:0]             input_pair_config,
	output logic                   temp_sensor_selected,
	output logic                   differential_selected,
	output logic [2:0]             gain_select_field,
	output logic [2:0]             gain_step,
	output logic                   conversion_busy,
	output logic                   conversion_done_flag,
	output logic                   conversion_done_pulse
);

	// ************************************************************
	// registers
	// ************************************************************
	logic              converter_enable;
	logic              track_mode_select;
	logic              window_compare_flag;
	logic              result_left_justify;
	start_mode_t       start_mode;
	logic [DIV_W-1:0]  sar_clock_divider_field;
	logic [N_BITS-1:0] result_code;
	logic              result_diff;
	conv_state_t       state;
	logic [1:0]        track_count;
	logic [N_BITS-1:0] sar_code;
	logic [N_BITS-1:0] trial;
	logic              pin_prev;
	logic              conv_diff;
	logic              dp_write;
	logic              dp_read;
	logic [31:0]       dp_addr;

	// ************************************************************
	// bus decode
	// ************************************************************
	wire addr_take = hsel && htrans[1] && hready;
	wire wr_ctl    = dp_write && (dp_addr == OFS_CONTROL);
	wire wr_cfg    = dp_write && (dp_addr == OFS_CONFIG);
	wire wr_pair   = dp_write && (dp_addr == OFS_PAIR);
	wire wr_chan   = dp_write && (dp_addr == OFS_CHANNEL);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dp_write <= 1'b0;
			dp_read  <= 1'b0;
			dp_addr  <= '0;
		end else begin
			dp_write <= addr_take && hwrite;
			dp_read  <= addr_take && !hwrite;
			if (addr_take) begin
				dp_addr <= haddr;
			end
		end
	end

	// ************************************************************
	// start selection and sar clock
	// ************************************************************
	wire sar_tick;
	wire idle      = (state == ST_IDLE);
	wire ext_mode  = (start_mode == START_EXTERNAL);
	wire pin_rise  = external_convert_start && !pin_prev;
	wire sw_start  = wr_ctl && hwdata[CTL_BUSY_BIT];
	wire lp_pin    = track_mode_select && ext_mode;
	wire conv_last = (state == ST_CONVERT) && sar_tick && trial[0];
	wire track_end = (state == ST_TRACK) && sar_tick
		&& (track_count == 2'(TRACK_SAR_CLOCKS - 1));
	logic start_request;

	always_comb begin
		unique case (start_mode)
			START_SOFTWARE: start_request = sw_start;
			START_TIMER3:   start_request = timer3_overflow;
			START_EXTERNAL: start_request = pin_rise;
			START_TIMER2:   start_request = timer2_overflow;
		endcase
	end

	// requests during a conversion fall through unused
	wire start_event = start_request && idle && converter_enable;

	sar_clock_divider #(
		.W(DIV_W)
	) u_divider (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.run      (!idle),
		.divisor  (sar_clock_divider_field),
		.sar_tick (sar_tick)
	);

	// ************************************************************
	// control register
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			converter_enable     <= CONTROL_RESET[CTL_ENABLE_BIT];
			track_mode_select    <= CONTROL_RESET[CTL_TRACK_BIT];
			conversion_done_flag <= CONTROL_RESET[CTL_DONE_BIT];
			window_compare_flag  <= CONTROL_RESET[CTL_WINDOW_BIT];
			result_left_justify  <= CONTROL_RESET[CTL_LJUST_BIT];
			start_mode           <= start_mode_t'(CONTROL_RESET[CTL_MODE_HI_BIT:CTL_MODE_LO_BIT]);
		end else begin
			if (wr_ctl) begin
				converter_enable    <= hwdata[CTL_ENABLE_BIT];
				track_mode_select   <= hwdata[CTL_TRACK_BIT];
				window_compare_flag <= hwdata[CTL_WINDOW_BIT];
				result_left_justify <= hwdata[CTL_LJUST_BIT];
				start_mode <= start_mode_t'(hwdata[CTL_MODE_HI_BIT:CTL_MODE_LO_BIT]);
			end
			// completion sets, a same-cycle clear loses
			if (conv_last) begin
				conversion_done_flag <= 1'b1;
			end else if (wr_ctl) begin
				conversion_done_flag <= hwdata[CTL_DONE_BIT];
			end
		end
	end

	// ************************************************************
	// configuration, pair and channel registers
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sar_clock_divider_field <= CONFIG_RESET[7:CFG_DIV_LSB];
			gain_select_field       <= CONFIG_RESET[2:CFG_GAIN_LSB];
			input_pair_config       <= PAIR_RESET;
			channel_select_field    <= CHANNEL_RESET;
		end else begin
			if (wr_cfg) begin
				sar_clock_divider_field <= hwdata[7:CFG_DIV_LSB];
				gain_select_field       <= hwdata[2:CFG_GAIN_LSB];
			end
			if (wr_pair) begin
				input_pair_config <= hwdata[3:0];
			end
			if (wr_chan) begin
				channel_select_field <= hwdata[3:0];
			end
		end
	end

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst || !converter_enable) begin
			state       <= ST_IDLE;
			track_count <= '0;
			sar_code    <= '0;
			trial       <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_event) begin
						sar_code    <= '0;
						trial       <= {1'b1, {(N_BITS-1){1'b0}}};
						track_count <= '0;
						// pin start in low power already tracked while low
						state <= (track_mode_select && !lp_pin) ? ST_TRACK : ST_CONVERT;
					end
				end
				ST_TRACK: begin
					if (track_end) begin
						state <= ST_CONVERT;
					end else if (sar_tick) begin
						track_count <= track_count + 2'h1;
					end
				end
				ST_CONVERT: begin
					if (sar_tick) begin
						if (comparator_high) begin
							sar_code <= sar_code | trial;
						end
						trial <= trial >> 1;
						if (trial[0]) begin
							state <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_prev    <= 1'b0;
			conv_diff   <= 1'b0;
			result_code <= '0;
			result_diff <= 1'b0;
		end else begin
			pin_prev <= external_convert_start;
			if (start_event) begin
				conv_diff <= differential_selected;
			end
			if (conv_last) begin
				result_code <= comparator_high ? (sar_code | trial) : sar_code;
				result_diff <= conv_diff;
			end
		end
	end

	// ************************************************************
	// analog side controls
	// ************************************************************
	wire [1:0] pair_index = channel_select_field[2:1];

	assign temp_sensor_selected  = channel_select_field[CHAN_TEMP_BIT];
	assign differential_selected = !temp_sensor_selected
		&& input_pair_config[pair_index];
	assign conversion_busy       = !idle;
	assign conversion_done_pulse = conv_last;
	assign analog_power_on       = converter_enable;
	assign sar_dac_code          = sar_code | trial;

	wire idle_track = lp_pin ? !external_convert_start : !track_mode_select;
	assign track_enable = converter_enable && !chip_sleep
		&& ((idle && idle_track) || state == ST_TRACK);

	// half is step 0, unity step 1, sixteen step 5
	function automatic logic [2:0] gain_code_to_step(input logic [2:0] code);
		logic [2:0] step;
		step = 3'h0;
		if (code[2]) begin
			step = code[1] ? 3'h0 : 3'h5;
		end else begin
			unique case (code)
				GAIN_ONE:   step = 3'h1;
				GAIN_TWO:   step = 3'h2;
				GAIN_FOUR:  step = 3'h3;
				GAIN_EIGHT: step = 3'h4;
			endcase
		end
		return step;
	endfunction

	assign gain_step = gain_code_to_step(gain_select_field);

	// ************************************************************
	// result justification and read data
	// ************************************************************
	// differential trials run offset-binary; flipping the msb gives two's complement
	wire [N_BITS-1:0] signed_code = result_diff ? {~result_code[N_BITS-1], result_code[N_BITS-2:0]}
		: result_code;
	wire       sign_fill = result_diff && signed_code[N_BITS-1];
	wire [7:0] right_high = {{6{sign_fill}}, signed_code[9:8]};
	wire [7:0] result_high_byte = result_left_justify ? signed_code[9:2] : right_high;
	wire [7:0] result_low_byte  = result_left_justify ? {signed_code[1:0], 6'h00}
		: signed_code[7:0];
	wire [7:0] control_read = {converter_enable, track_mode_select, conversion_done_flag,
		conversion_busy, start_mode, window_compare_flag, result_left_justify};
	wire [7:0] config_read  = {sar_clock_divider_field, gain_select_field};
	logic [7:0] read_byte;

	always_comb begin
		read_byte = 8'h00;
		if (dp_addr == OFS_CONTROL)  read_byte = control_read;
		if (dp_addr == OFS_CONFIG)   read_byte = config_read;
		if (dp_addr == OFS_PAIR)     read_byte = {4'h0, input_pair_config};
		if (dp_addr == OFS_CHANNEL)  read_byte = {4'h0, channel_select_field};
		if (dp_addr == OFS_RES_HIGH) read_byte = result_high_byte;
		if (dp_addr == OFS_RES_LOW)  read_byte = result_low_byte;
	end

	assign hrdata = dp_read ? {24'h000000, read_byte} : 32'h0000_0000;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_disabled_idle: assert property (!converter_enable |=> !conversion_busy)
		else $error("conversion running while disabled");
	chk_pair_reset: assert property ($fell(rst) |-> input_pair_config == 4'h0)
		else $error("pair config not single-ended after reset");
	chk_gain_reset: assert property ($fell(rst) |-> gain_step == 3'h1)
		else $error("gain not unity after reset");
	chk_start_busy: assert property (start_event |=> conversion_busy)
		else $error("start did not raise busy");
	chk_done_fall: assert property ($fell(conversion_busy) && converter_enable
		|-> conversion_done_flag && control_read[CTL_DONE_BIT])
		else $error("busy fell without done flag");
	chk_busy_ends: assert property (conv_last |=> !conversion_busy)
		else $error("busy still high after last trial");
	chk_track_three: assert property (track_end |-> track_count == 2'h2
		##1 state == ST_CONVERT)
		else $error("low-power tracking not three sar clocks");
	chk_idle_tracks: assert property (idle && converter_enable && !chip_sleep
		&& !track_mode_select |-> track_enable)
		else $error("no tracking while idle in default mode");
	chk_pin_track: assert property (idle && converter_enable && !chip_sleep && lp_pin
		|-> track_enable == !external_convert_start)
		else $error("pin low-power tracking wrong");
	chk_sleep_off: assert property (chip_sleep |-> !track_enable)
		else $error("tracking during chip sleep");
	chk_start_ignored: assert property (state == ST_CONVERT && start_request && !sar_tick
		|=> $stable(trial))
		else $error("start disturbed a conversion");
	chk_gain_decode: assert property (gain_select_field[2:1] == 2'b11 |-> gain_step == 3'h0)
		else $error("half gain code misdecoded");
	chk_left_justify: assert property (result_left_justify |-> result_low_byte[5:0] == 6'h00)
		else $error("left-justified low bits not zero");

	cov_sw_conversion: cover property (sw_start && start_event ##[1:400] conv_last);
	cov_low_power:     cover property (state == ST_TRACK ##[1:200] state == ST_CONVERT);
	cov_pin_start:     cover property (ext_mode && start_event);
	cov_differential:  cover property (conv_last && conv_diff);

endmodule
`default_nettype wire

// [sar_adc_pkg.sv]
// shared constants and types of the successive-approximation converter control
package sar_adc_pkg;

	// ************************************************************
	// widths and timing
	// ************************************************************
	localparam int RESULT_BITS      = 10;
	localparam int DIV_W            = 5;
	localparam int TRACK_SAR_CLOCKS = 3;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [31:0] OFS_CONTROL  = 32'h0000_0000;
	localparam logic [31:0] OFS_CONFIG   = 32'h0000_0004;
	localparam logic [31:0] OFS_PAIR     = 32'h0000_0008;
	localparam logic [31:0] OFS_CHANNEL  = 32'h0000_000C;
	localparam logic [31:0] OFS_RES_HIGH = 32'h0000_0010;
	localparam logic [31:0] OFS_RES_LOW  = 32'h0000_0014;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTL_ENABLE_BIT  = 7;
	localparam int CTL_TRACK_BIT   = 6;
	localparam int CTL_DONE_BIT    = 5;
	localparam int CTL_BUSY_BIT    = 4;
	localparam int CTL_MODE_HI_BIT = 3;
	localparam int CTL_MODE_LO_BIT = 2;
	localparam int CTL_WINDOW_BIT  = 1;
	localparam int CTL_LJUST_BIT   = 0;
	localparam int CFG_DIV_LSB     = 3;
	localparam int CFG_GAIN_LSB    = 0;
	localparam int CHAN_TEMP_BIT   = 3;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET  = 8'hF8;
	localparam logic [3:0] PAIR_RESET    = 4'h0;
	localparam logic [3:0] CHANNEL_RESET = 4'h0;

	// ************************************************************
	// encodings
	// ************************************************************
	typedef enum logic [1:0] {
		START_SOFTWARE = 2'b00,
		START_TIMER3   = 2'b01,
		START_EXTERNAL = 2'b10,
		START_TIMER2   = 2'b11
	} start_mode_t;

	localparam logic [2:0] GAIN_ONE   = 3'h0;
	localparam logic [2:0] GAIN_TWO   = 3'h1;
	localparam logic [2:0] GAIN_FOUR  = 3'h2;
	localparam logic [2:0] GAIN_EIGHT = 3'h3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TRACK,
		ST_CONVERT
	} conv_state_t;

endpackage

// [sar_clock_divider.sv]
// divider that turns the system clock into one-cycle sar clock enables
`timescale 1ns/1ps
`default_nettype none
module sar_clock_divider
	import sar_adc_pkg::*;
#(
	parameter int W = DIV_W
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         run,
	input  wire logic [W-1:0] divisor,
	output logic              sar_tick
);

	logic [W-1:0] count;

	// period is divisor plus one system clocks
	assign sar_tick = run && (count == divisor);

	always_ff @(posedge ref_clk) begin
		if (rst || !run || sar_tick) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
		sar_tick && run && divisor != '0 |=> !sar_tick)
		else $error("sar tick repeated inside one divided period");

endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
	$display("Error %s expected %0h seen %0h", nm, (ex), (got)); end end
module tb
	import sar_adc_pkg::*;
;
	logic        ref_clk, rst, hsel, hwrite, hready, chip_sleep;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, gain_select_field, gain_step;
	logic        hreadyout, hresp, cmp_high, t3, t2, pin;
	logic        power_on, track_enable, busy, done_flag, done_pulse, temp_sel, diff_sel;
	logic [9:0]  dac_code, input_level;
	logic [3:0]  chan_field, pair_field;
	int          fails = 0;
	int          cmp_count = 0;
	int          pulses = 0;

	always @(posedge ref_clk) begin
		if (done_pulse === 1'b1) pulses++;
	end

	assign hready = hreadyout;

	sar_adc_control i_sar_adc_control (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.timer3_overflow(t3), .timer2_overflow(t2), .external_convert_start(pin),
		.chip_sleep(chip_sleep), .comparator_high(cmp_high), .analog_power_on(power_on),
		.track_enable(track_enable), .sar_dac_code(dac_code),
		.channel_select_field(chan_field), .input_pair_config(pair_field),
		.temp_sensor_selected(temp_sel), .differential_selected(diff_sel),
		.gain_select_field(gain_select_field), .gain_step(gain_step),
		.conversion_busy(busy), .conversion_done_flag(done_flag),
		.conversion_done_pulse(done_pulse));

	analog_front_model i_analog_front_model (.ref_clk(ref_clk), .sar_dac_code(dac_code),
		.input_level(input_level), .comparator_high(cmp_high), .timer3_overflow(t3),
		.timer2_overflow(t2), .external_convert_start(pin));

	// ************************************************************
	// bus and timing helpers
	// ************************************************************
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic ahb(input logic wr_en, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr_en;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		q = hrdata;
		#1;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] ex, input string nm);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		`CHECK(nm, ex, q)
	endtask

	// waits for busy, returns its length and tracking state in its first cycle
	task automatic conv_len(output int n, output logic trk);
		int w;
		w = 0;
		n = 0;
		while (busy !== 1'b1 && w < 40) begin
			tick();
			w++;
		end
		trk = track_enable;
		while (busy === 1'b1 && n < 3000) begin
			tick();
			n++;
		end
		repeat (1000) @(posedge ref_clk);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		rd(OFS_CONTROL, 32'h0000_0000, "control");
		rd(OFS_CONFIG, 32'h0000_00F8, "config");
		rd(OFS_PAIR, 32'h0000_0000, "pair");
		rd(OFS_CHANNEL, 32'h0000_0000, "channel");
		rd(32'h0000_0018, 32'h0000_0000, "unmapped");
		`CHECK("gain_step", 3'h1, gain_step)
		`CHECK("power", 1'b0, power_on)
		`CHECK("track", 1'b0, track_enable)
		`CHECK("hresp", 1'b0, hresp)
	endtask

	task automatic t_soft();
		int n;
		logic trk;
		int p0;
		p0 = pulses;
		input_level = 10'h2A5;
		wr(OFS_CONFIG, 32'h0000_0000);
		wr(OFS_CHANNEL, 32'h0000_0001);
		wr(OFS_CONTROL, 32'h0000_0080);
		`CHECK("idle track", 1'b1, track_enable)
		wr(OFS_CONTROL, 32'h0000_0090);
		conv_len(n, trk);
		`CHECK("busy len", 10, n)
		`CHECK("busy track", 1'b0, trk)
		`CHECK("done pulse", p0 + 1, pulses)
		`CHECK("done flag", 1'b1, done_flag)
		rd(OFS_CONTROL, 32'h0000_00A0, "done");
		rd(OFS_RES_HIGH, 32'h0000_0002, "res high");
		rd(OFS_RES_LOW, 32'h0000_00A5, "res low");
	endtask

	task automatic t_diff();
		int n;
		logic trk;
		input_level = 10'h155;
		wr(OFS_CONFIG, 32'h0000_0018);
		wr(OFS_PAIR, 32'h0000_0001);
		wr(OFS_CHANNEL, 32'h0000_0000);
		`CHECK("diff sel", 1'b1, diff_sel)
		wr(OFS_CONTROL, 32'h0000_0081);
		wr(OFS_CONTROL, 32'h0000_0091);
		conv_len(n, trk);
		`CHECK("div3 len", 40, n)
		rd(OFS_RES_HIGH, 32'h0000_00D5, "left high");
		rd(OFS_RES_LOW, 32'h0000_0040, "left low");
		wr(OFS_CONTROL, 32'h0000_0080);
		wr(OFS_CONTROL, 32'h0000_0090);
		conv_len(n, trk);
		rd(OFS_RES_HIGH, 32'h0000_00FF, "sign high");
		rd(OFS_RES_LOW, 32'h0000_0055, "sign low");
	endtask

	task automatic t_sources();
		int n;
		logic trk;
		wr(OFS_CONFIG, 32'h0000_0000);
		for (int m = 1; m < 4; m++) begin
			wr(OFS_CONTROL, 32'h80 | (m << 2));
			i_analog_front_model.fire((m % 3) + 1);
			i_analog_front_model.fire(((m + 1) % 3) + 1);
			tick();
			`CHECK("other source", 1'b0, busy)
			fork
				conv_len(n, trk);
				begin
					i_analog_front_model.fire(m);
					repeat (3) @(posedge ref_clk);
					i_analog_front_model.fire(m);
				end
			join
			`CHECK("source len", 10, n)
		end
	endtask

	task automatic t_lowpower();
		int n;
		logic trk;
		wr(OFS_CONFIG, 32'h0000_0008);
		wr(OFS_CONTROL, 32'h0000_00C0);
		wr(OFS_CONTROL, 32'h0000_00D0);
		conv_len(n, trk);
		`CHECK("lp len", 26, n)
		`CHECK("lp track", 1'b1, trk)
		wr(OFS_CONTROL, 32'h0000_00C8);
		`CHECK("pin low track", 1'b1, track_enable)
		fork
			conv_len(n, trk);
			i_analog_front_model.fire(2);
		join
		`CHECK("pin len", 20, n)
	endtask

	task automatic t_sleep();
		wr(OFS_CONTROL, 32'h0000_0080);
		@(posedge ref_clk);
		chip_sleep <= 1'b1;
		tick();
		`CHECK("sleep track", 1'b0, track_enable)
		chip_sleep <= 1'b0;
	endtask

	task automatic t_mux();
		logic [2:0] steps [8] = '{3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd5, 3'd0, 3'd0};
		for (int k = 0; k < 8; k++) begin
			wr(OFS_CONFIG, 32'(k));
			`CHECK("gain field", 3'(k), gain_select_field)
			`CHECK("gain step", steps[k], gain_step)
		end
		wr(OFS_PAIR, 32'h0000_000A);
		`CHECK("pair field", 4'hA, pair_field)
		for (int c = 0; c < 9; c++) begin
			wr(OFS_CHANNEL, 32'(c));
			`CHECK("chan field", 4'(c), chan_field)
			`CHECK("temp", 1'(c == 8), temp_sel)
			`CHECK("pair", 1'((c < 8) && c[1]), diff_sel)
		end
	endtask

	task automatic t_abort();
		wr(OFS_CONFIG, 32'h0000_0038);
		wr(OFS_CONTROL, 32'h0000_0080);
		wr(OFS_CONTROL, 32'h0000_0090);
		repeat (20) tick();
		wr(OFS_CONTROL, 32'h0000_0000);
		tick();
		`CHECK("abort busy", 1'b0, busy)
		rd(OFS_CONTROL, 32'h0000_0000, "abort done");
		wr(OFS_CONTROL, 32'h0000_0010);
		repeat (3) tick();
		`CHECK("off start", 1'b0, busy)
		`CHECK("off power", 1'b0, power_on)
	endtask

	// ************************************************************
	// run control
	// ************************************************************
	task automatic end_sim();
		if (fails == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		#400000;
		fails++;
		end_sim();
	end

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		chip_sleep = 1'b0;
		input_level = 10'h000;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_soft();
		t_diff();
		t_sources();
		t_lowpower();
		t_sleep();
		t_mux();
		t_abort();
		end_sim();
	end
endmodule
`default_nettype wire
